// ---- tsg_pkg.sv ----
// package of constants and types for the trigger source and gate control block
package tsg_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int LOOP_W  = 20;
  localparam int TIMER_W = 32;

  localparam logic [LOOP_W-1:0] LOOP_MIN = 20'h0_0001;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hF_4240; // 1,000,000
  localparam logic [TIMER_W-1:0] TIMER_MIN = 32'h0000_0001;

  // time unit for start-to-start spacing, in ns, and clock period
  localparam int TIME_UNIT_NS = 20;
  localparam int CLK_NS       = 20;
  localparam int UNIT_CYC     = (TIME_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [TIMER_W-1:0] UNIT_CYC_V = TIMER_W'(UNIT_CYC);

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    RUN_CONT = 2'h0,
    RUN_TRIG = 2'h1,
    RUN_GATE = 2'h3
  } tsg_run_t;

  typedef enum logic [2:0] {
    SRC_EXT   = 3'h0,
    SRC_EVENT = 3'h1,
    SRC_BUS   = 3'h2,
    SRC_INT   = 3'h3,
    SRC_MAN   = 3'h4
  } tsg_src_t;

  typedef enum logic [1:0] {
    SLOPE_RISE = 2'h0,
    SLOPE_FALL = 2'h1,
    SLOPE_BOTH = 2'h2
  } tsg_slope_t;

  typedef enum logic [1:0] {
    TMR_OFF       = 2'h0,
    TMR_START     = 2'h1,
    TMR_STOPSTART = 2'h2
  } tsg_tmr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_WAIT = 2'h3
  } tsg_state_t;

  // feature bit positions in the permitted-feature vector
  localparam int FT_ARM   = 0;
  localparam int FT_DELAY = 1;
  localparam int FT_BURST = 2;
  localparam int FT_OVR   = 3;
  localparam int FT_WIDTH = 4;
  localparam int FT_HOLD  = 5;
  localparam int FT_TIMER = 6;
  localparam int FT_RETRG = 7;
  localparam int FT_W     = 8;

  localparam logic [FT_W-1:0] FEAT_EXT   = 8'h3E;
  localparam logic [FT_W-1:0] FEAT_EVENT = 8'hC7;
  localparam logic [FT_W-1:0] FEAT_INT   = 8'hC4;
  localparam logic [FT_W-1:0] FEAT_BUS   = 8'h3F;
  localparam logic [FT_W-1:0] FEAT_MAN   = 8'h0E;
  localparam logic [FT_W-1:0] FEAT_NONE  = 8'h00;
endpackage : tsg_pkg

// ---- tsg_edge.sv ----
// synchroniser and selectable edge detector for one outside input
`timescale 1ns/1ps
module tsg_edge
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               pin,
  input  wire tsg_pkg::tsg_slope_t slope,
  output logic                    level,
  output logic                    pulse
);
  import tsg_pkg::*;

  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic       lvl_r;
  logic       lvl_nxt;
  logic       rise;
  logic       fall;

  // ****************************************
  // three stage capture
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      s1_r  <= pin;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // level moves only once stages two and three agree, one pulse per move
  assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  assign rise    = lvl_nxt & ~lvl_r;
  assign fall    = ~lvl_nxt & lvl_r;
  assign level   = lvl_r;
  assign pulse   = (slope == SLOPE_RISE) ? rise :
                   (slope == SLOPE_FALL) ? fall :
                   (slope == SLOPE_BOTH) ? (rise | fall) : 1'b0;
endmodule : tsg_edge

// ---- tsg_ctr.sv ----
// loadable down counter reporting when it reaches one
`timescale 1ns/1ps
module tsg_ctr
#(
  parameter int W = 20
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         dec,
  output logic              last
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // ****************************************
  // count
  // ****************************************
  assign cnt_nxt = load ? value : (dec && cnt_r > W'(1)) ? cnt_r - W'(1) : cnt_r;
  assign last    = (cnt_r <= W'(1));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= W'(1);
    else
      cnt_r <= cnt_nxt;
  end
endmodule : tsg_ctr

// ---- tsg_ctrl.sv ----
// trigger source selection, gating, arming and loop control for one channel
`timescale 1ns/1ps
module tsg_ctrl
(
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           trig_pin,
  input  wire logic                           event_pin,
  input  wire logic                           manual_trigger_button,
  input  wire logic                           bus_trigger,
  input  wire logic                           bus_abort,
  input  wire tsg_pkg::tsg_run_t              run_mode,
  input  wire tsg_pkg::tsg_src_t              source,
  input  wire logic                           armed_mode,
  input  wire tsg_pkg::tsg_slope_t            trig_slope,
  input  wire logic                           event_slope_fall,
  input  wire logic                           gate_level_high,
  input  wire tsg_pkg::tsg_slope_t            gate_open_slope,
  input  wire tsg_pkg::tsg_slope_t            gate_close_slope,
  input  wire tsg_pkg::tsg_tmr_t              timer_mode,
  input  wire logic [tsg_pkg::TIMER_W-1:0]    timer_interval,
  input  wire logic [tsg_pkg::LOOP_W-1:0]     wave_loops,
  input  wire logic [tsg_pkg::LOOP_W-1:0]     seq_loops,
  input  wire logic                           seq_enable,
  input  wire logic                           jump_bit,
  input  wire logic                           cycle_done,
  output logic                                start_pulse,
  output logic                                step_advance,
  output logic                                seq_wrap,
  output logic                                output_active,
  output logic                                idle_dc,
  output logic                                gate_open,
  output logic                                delay_allowed,
  output logic [tsg_pkg::FT_W-1:0]            feature_allow,
  output logic                                config_error
);
  import tsg_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  tsg_state_t             state_r;
  tsg_state_t             state_nxt;
  logic                   gate_r;
  logic                   gate_nxt;
  logic                   enabled_r;
  logic                   enabled_nxt;
  logic                   start_r;
  logic                   step_r;
  logic                   wrap_r;
  logic                   dc_r;
  logic [TIMER_W-1:0]     tmr_r;
  logic [TIMER_W-1:0]     tmr_nxt;
  logic                   tmr_wait_r;
  logic                   trig_lvl;
  logic                   trig_edge;
  logic                   gopen_edge;
  logic                   gclose_edge;
  logic                   event_lvl;
  logic                   event_edge;
  logic                   man_lvl;
  logic                   man_rise;
  tsg_slope_t             event_slope;
  logic                   timer_on;
  logic                   en_ext;
  logic                   en_event;
  logic                   en_bus;
  logic                   en_int;
  logic                   en_man;
  logic                   tmr_fire;
  logic [TIMER_W-1:0]     tmr_reload;
  logic                   src_trig;
  logic                   gate_in_lvl;
  logic                   gate_in_open;
  logic                   gate_in_close;
  logic                   gated;
  logic                   wave_last;
  logic                   seq_last;
  logic                   cycle_end;
  logic                   jump_ok;
  logic                   loops_bad;
  logic [LOOP_W-1:0]      wave_ld;
  logic [LOOP_W-1:0]      seq_ld;
  logic                   begin_run;

  // ****************************************
  // input capture
  // ****************************************
  // trigger input sampled once for trigger slope; the gating level of the chosen input once per gate slope
  tsg_edge u_trig
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (trig_pin),
    .slope  (trig_slope),
    .level  (trig_lvl),
    .pulse  (trig_edge)
  );

  tsg_edge u_gopen
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (gated ? gate_in_lvl : 1'b0),
    .slope  (gate_open_slope),
    .level  (),
    .pulse  (gopen_edge)
  );

  tsg_edge u_gclose
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (gated ? gate_in_lvl : 1'b0),
    .slope  (gate_close_slope),
    .level  (),
    .pulse  (gclose_edge)
  );

  // event input has no both-edges choice
  assign event_slope = event_slope_fall ? SLOPE_FALL : SLOPE_RISE;

  tsg_edge u_event
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (event_pin),
    .slope  (event_slope),
    .level  (event_lvl),
    .pulse  (event_edge)
  );

  tsg_edge u_man
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (manual_trigger_button),
    .slope  (SLOPE_RISE),
    .level  (man_lvl),
    .pulse  (man_rise)
  );

  // ****************************************
  // source enables per run mode and source
  // ****************************************
  // one source selected at a time, but SRC_EXT in triggered mode enables both the trigger pin and the button
  assign timer_on = (timer_mode != TMR_OFF) && (source == SRC_INT);
  assign gated    = (run_mode == RUN_GATE);
  assign en_ext   = (source == SRC_EXT) && !timer_on
                    && (run_mode != RUN_CONT || armed_mode);
  assign en_man   = (source == SRC_EXT) && !timer_on
                    && (run_mode == RUN_TRIG);
  assign en_event = (source == SRC_EVENT) && !timer_on
                    && (run_mode != RUN_CONT || armed_mode);
  assign en_bus   = (source == SRC_BUS) && !timer_on && !gated
                    && (run_mode != RUN_CONT || armed_mode);
  assign en_int   = timer_on && (run_mode == RUN_TRIG);

  // gating level follows the chosen input; button gates in front-panel initiate
  assign gate_in_lvl = (source == SRC_MAN) ? man_lvl :
                       (source == SRC_EVENT) ? event_lvl : trig_lvl;
  assign gate_in_open  = gopen_edge && (gate_in_lvl == gate_level_high);
  assign gate_in_close = gclose_edge && (gate_in_lvl != gate_level_high);

  // ****************************************
  // internal timer
  // ****************************************
  // start-to-start counts from each start; stop-to-start from each cycle end
  assign tmr_reload = (timer_mode == TMR_START) ? TIMER_W'(timer_interval * UNIT_CYC_V)
                                                : timer_interval;
  assign tmr_fire   = en_int && !tmr_wait_r && (tmr_r <= TIMER_MIN);
  assign tmr_nxt    = !en_int ? tmr_reload :
                      (tmr_fire && timer_mode == TMR_START) ? tmr_reload :
                      (timer_mode == TMR_STOPSTART && cycle_end) ? tmr_reload :
                      (!tmr_wait_r && tmr_r > TIMER_MIN) ? tmr_r - TIMER_MIN : tmr_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tmr_r      <= TIMER_MIN;
      tmr_wait_r <= 1'b0;
    end
    else
    begin
      tmr_r      <= tmr_nxt;
      // stop-to-start holds the count while a cycle is running
      tmr_wait_r <= en_int && (timer_mode == TMR_STOPSTART)
                    && (tmr_fire || (tmr_wait_r && !cycle_end));
    end
  end

  // ****************************************
  // trigger merge
  // ****************************************
  assign src_trig = (en_ext && trig_edge) || (en_man && man_rise)
                    || (en_event && event_edge) || (en_bus && bus_trigger)
                    || tmr_fire;

  // ****************************************
  // loop counters
  // ****************************************
  // out-of-range counts are clamped and flagged
  assign wave_ld = (wave_loops < LOOP_MIN) ? LOOP_MIN :
                   (wave_loops > LOOP_MAX) ? LOOP_MAX : wave_loops;
  assign seq_ld  = (seq_loops < LOOP_MIN) ? LOOP_MIN :
                   (seq_loops > LOOP_MAX) ? LOOP_MAX : seq_loops;
  assign loops_bad = (wave_loops < LOOP_MIN) || (wave_loops > LOOP_MAX)
                     || (seq_loops < LOOP_MIN) || (seq_loops > LOOP_MAX);

  assign begin_run = (state_nxt == ST_RUN) && (state_r == ST_IDLE);
  // a step moves on at a plain step end, or when the jump event ends a wait
  assign jump_ok   = (cycle_end && wave_last && !jump_bit)
                     || (state_r == ST_WAIT && state_nxt == ST_RUN);
  assign cycle_end = (state_r == ST_RUN) && cycle_done;

  tsg_ctr #(.W(LOOP_W)) u_wave
  (
    .clk    (clk),
    .resetn (resetn),
    .load   (begin_run || (seq_enable && jump_ok) || (state_r == ST_IDLE)),
    .value  (wave_ld),
    .dec    (cycle_end),
    .last   (wave_last)
  );

  tsg_ctr #(.W(LOOP_W)) u_seq
  (
    .clk    (clk),
    .resetn (resetn),
    .load   (begin_run || (state_r == ST_IDLE)),
    .value  (seq_ld),
    .dec    (seq_wrap),
    .last   (seq_last)
  );

  // ****************************************
  // run state machine
  // ****************************************
  // gated mode is forced armed, so the self-armed start never applies;
  // in gated mode the enable is the gate itself, so no stale enable carries over
  assign enabled_nxt = bus_abort ? 1'b0 :
                       (gated ? gate_nxt
                              : (enabled_r || !armed_mode ||
                                 (run_mode == RUN_CONT && en_event && event_edge)));
  assign gate_nxt    = bus_abort ? 1'b0 :
                       gate_in_open ? 1'b1 : gate_in_close ? 1'b0 : gate_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (!bus_abort && ((gated && gate_in_open) ||
            (!gated && enabled_nxt && (run_mode == RUN_CONT || src_trig))))
          state_nxt = ST_RUN;
      ST_RUN:
        if (bus_abort || (gated && gate_in_close))
          state_nxt = ST_IDLE;
        else if (cycle_end && wave_last && seq_enable && jump_bit)
          state_nxt = ST_WAIT;
        else if (cycle_end && wave_last && (!seq_enable || seq_last)
                 && run_mode == RUN_TRIG)
          state_nxt = ST_IDLE;
      ST_WAIT:
        if (bus_abort || (gated && gate_in_close))
          state_nxt = ST_IDLE;
        else if (event_edge)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= ST_IDLE;
      gate_r    <= 1'b0;
      enabled_r <= 1'b0;
      start_r   <= 1'b0;
      step_r    <= 1'b0;
      wrap_r    <= 1'b0;
      dc_r      <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      gate_r    <= gate_nxt;
      enabled_r <= enabled_nxt;
      start_r   <= begin_run;
      step_r    <= seq_enable && jump_ok;
      wrap_r    <= seq_enable && jump_ok && !seq_last;
      dc_r      <= (armed_mode || gated) && !enabled_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign start_pulse   = start_r;
  assign step_advance  = step_r;
  assign seq_wrap      = wrap_r;
  assign output_active = (state_r != ST_IDLE) && (!gated || gate_r);
  assign idle_dc       = dc_r;
  assign gate_open     = gate_r;
  assign delay_allowed = !gated && feature_allow[FT_DELAY];
  assign feature_allow = gated ? (FEAT_EXT & ~(8'h01 << FT_RETRG)) :
                         (source == SRC_EXT)   ? FEAT_EXT :
                         (source == SRC_EVENT) ? FEAT_EVENT :
                         (source == SRC_INT)   ? FEAT_INT :
                         (source == SRC_BUS)   ? FEAT_BUS :
                         (source == SRC_MAN)   ? FEAT_MAN : FEAT_NONE;
  assign config_error  = loops_bad || (gated && !armed_mode)
                         || (gated && (source == SRC_BUS || source == SRC_INT));
endmodule : tsg_ctrl

// ---- tsg_ctrl_asserts.sv ----
// concurrent checks on the ports of the trigger and gate control block
`timescale 1ns/1ps
module tsg_ctrl_asserts
  import tsg_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  bus_trigger,
  input wire logic                  bus_abort,
  input wire tsg_pkg::tsg_run_t     run_mode,
  input wire tsg_pkg::tsg_src_t     source,
  input wire logic                  armed_mode,
  input wire logic [LOOP_W-1:0]     wave_loops,
  input wire logic [LOOP_W-1:0]     seq_loops,
  input wire logic                  seq_enable,
  input wire logic                  start_pulse,
  input wire logic                  output_active,
  input wire logic                  delay_allowed,
  input wire logic [FT_W-1:0]       feature_allow,
  input wire logic                  config_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ****************************************
  // sequences
  // ****************************************
  sequence abort_s;
    bus_abort;
  endsequence
  sequence quiet_s;
    !output_active;
  endsequence
  // registered start may lag the command by one extra clock
  sequence bus_cmd_s;
    $past(bus_trigger) || $past(bus_trigger, 2);
  endsequence

  // ****************************************
  // properties
  // ****************************************
  abort_stop_a: assert property (abort_s |=> quiet_s)
    else $error("output still active after abort");
  bus_cause_a: assert property (start_pulse && source == SRC_BUS |-> bus_cmd_s)
    else $error("bus source started without a bus command");
  start_once_a: assert property (start_pulse |=> !start_pulse)
    else $error("start pulse longer than one cycle");
  feat_map_a: assert property (run_mode == RUN_TRIG |-> feature_allow ==
    (source == SRC_EXT ? FEAT_EXT : source == SRC_EVENT ? FEAT_EVENT :
     source == SRC_INT ? FEAT_INT : source == SRC_BUS ? FEAT_BUS : FEAT_MAN))
    else $error("feature vector wrong for source");
  gate_delay_a: assert property (run_mode == RUN_GATE |-> !delay_allowed)
    else $error("delay allowed in gated mode");
  gate_arm_a: assert property (run_mode == RUN_GATE && !armed_mode |-> config_error)
    else $error("gated self-armed not flagged");
  gate_src_a: assert property (run_mode == RUN_GATE && source inside {SRC_BUS, SRC_INT}
    |-> config_error)
    else $error("gated with bus or timer source not flagged");
  loop_range_a: assert property (wave_loops == 0 || wave_loops > LOOP_MAX |-> config_error)
    else $error("wave loop count out of range not flagged");
  seq_range_a: assert property (seq_enable && (seq_loops == 0 || seq_loops > LOOP_MAX)
    |-> config_error)
    else $error("sequence loop count out of range not flagged");
endmodule : tsg_ctrl_asserts

bind tsg_ctrl tsg_ctrl_asserts chk_u (.clk(clk), .resetn(resetn), .bus_trigger(bus_trigger),
  .bus_abort(bus_abort), .run_mode(run_mode), .source(source), .armed_mode(armed_mode),
  .wave_loops(wave_loops), .seq_loops(seq_loops), .seq_enable(seq_enable),
  .start_pulse(start_pulse), .output_active(output_active), .delay_allowed(delay_allowed),
  .feature_allow(feature_allow), .config_error(config_error));

// ---- tsg_src_model.sv ----
// model of the outside trigger, event and button sources
`timescale 1ns/1ps
module tsg_src_model
(
  input  wire logic clk,
  output logic      trig_pin,
  output logic      event_pin,
  output logic      manual_trigger_button
);
  // quiet levels at start, so no spurious edge after reset
  initial
  begin
    trig_pin = 1'b0;
    event_pin = 1'b0;
    manual_trigger_button = 1'b0;
  end

  // levels change off the sampling edge; each is held until changed again
  task automatic drive(input int which, input logic v);
    @(negedge clk);
    case (which)
      0: trig_pin = v;
      1: event_pin = v;
      default: manual_trigger_button = v;
    endcase
  endtask : drive
endmodule : tsg_src_model

// ---- test_tsg_ctrl.sv ----
// self-checking bench for the trigger source and gate control block
`timescale 1ns/1ps
module test_tsg_ctrl;
  import tsg_pkg::*;
  logic clk, resetn, trig_pin, event_pin, manual_trigger_button, bus_trigger, bus_abort;
  logic armed_mode, event_slope_fall, gate_level_high, seq_enable, jump_bit, cycle_done;
  tsg_run_t   run_mode;
  tsg_src_t   source;
  tsg_slope_t trig_slope, gate_open_slope, gate_close_slope;
  tsg_tmr_t   timer_mode;
  logic [TIMER_W-1:0] timer_interval;
  logic [LOOP_W-1:0]  wave_loops, seq_loops;
  logic start_pulse, step_advance, seq_wrap, output_active, idle_dc, gate_open, delay_allowed;
  logic [FT_W-1:0] feature_allow;
  logic config_error;
  int err_count, compares, cycles, n;

  tsg_ctrl dut_u (.clk(clk), .resetn(resetn), .trig_pin(trig_pin), .event_pin(event_pin),
    .manual_trigger_button(manual_trigger_button), .bus_trigger(bus_trigger),
    .bus_abort(bus_abort), .run_mode(run_mode), .source(source), .armed_mode(armed_mode),
    .trig_slope(trig_slope), .event_slope_fall(event_slope_fall),
    .gate_level_high(gate_level_high), .gate_open_slope(gate_open_slope),
    .gate_close_slope(gate_close_slope), .timer_mode(timer_mode),
    .timer_interval(timer_interval), .wave_loops(wave_loops), .seq_loops(seq_loops),
    .seq_enable(seq_enable), .jump_bit(jump_bit), .cycle_done(cycle_done),
    .start_pulse(start_pulse), .step_advance(step_advance), .seq_wrap(seq_wrap),
    .output_active(output_active), .idle_dc(idle_dc), .gate_open(gate_open),
    .delay_allowed(delay_allowed), .feature_allow(feature_allow),
    .config_error(config_error));
  tsg_src_model src_u (.clk(clk), .trig_pin(trig_pin), .event_pin(event_pin),
    .manual_trigger_button(manual_trigger_button));

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // generous ceiling: the whole sequence needs well under a thousand clocks
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      give_verdict();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic [FT_W-1:0] exp_feat(input tsg_src_t s);
    case (s)
      SRC_EXT: return FEAT_EXT;
      SRC_EVENT: return FEAT_EVENT;
      SRC_INT: return FEAT_INT;
      SRC_BUS: return FEAT_BUS;
      default: return FEAT_MAN;
    endcase
  endfunction : exp_feat
  // start pulses stand one cycle, so a sample every falling edge sees each once
  task automatic count_starts(output int c);
    c = int'(start_pulse === 1'b1);
    repeat (12) @(negedge clk) if (start_pulse === 1'b1) c++;
  endtask : count_starts
  task automatic bus_pulse(input logic abort);
    @(negedge clk);
    if (abort) bus_abort = 1'b1; else bus_trigger = 1'b1;
    @(negedge clk);
    bus_abort = 1'b0;
    bus_trigger = 1'b0;
  endtask : bus_pulse
  task automatic done_pulse();
    @(negedge clk);
    cycle_done = 1'b1;
    @(negedge clk);
    cycle_done = 1'b0;
  endtask : done_pulse
  task automatic cfg(input tsg_run_t rm, input tsg_src_t s, input logic arm);
    @(negedge clk);
    run_mode = rm;
    source = s;
    armed_mode = arm;
    @(negedge clk);
  endtask : cfg
  task automatic pin_starts(input int which, input logic v, input int exp);
    src_u.drive(which, v);
    count_starts(n);
    check("starts", n, exp);
    bus_pulse(1'b1);
    check("active", output_active, 0);
  endtask : pin_starts

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {resetn, bus_trigger, bus_abort, armed_mode, event_slope_fall, seq_enable} = '0;
    {jump_bit, cycle_done, gate_level_high} = '0;
    run_mode = RUN_TRIG; source = SRC_EXT; trig_slope = SLOPE_RISE;
    gate_open_slope = SLOPE_RISE; gate_close_slope = SLOPE_FALL; timer_mode = TMR_OFF;
    timer_interval = TIMER_MIN; wave_loops = LOOP_MAX; seq_loops = LOOP_MIN;
    err_count = 0; compares = 0; cycles = 0;
    void'($urandom(32'h186a));
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    // feature table per source, then gated refusals
    for (int s = 0; s < 5; s++)
    begin
      cfg(RUN_TRIG, tsg_src_t'(s), 1'b0);
      check("feature_allow", feature_allow, exp_feat(tsg_src_t'(s)));
    end
    cfg(RUN_GATE, SRC_EXT, 1'b0);
    check("delay_allowed", delay_allowed, 0);
    check("config_error", config_error, 1);
    cfg(RUN_GATE, SRC_BUS, 1'b1);
    check("config_error", config_error, 1);
    // loop count bounds with a random legal value between
    cfg(RUN_TRIG, SRC_EXT, 1'b0);
    wave_loops = LOOP_W'(1 + $urandom % 1000000);
    @(negedge clk);
    check("config_error", config_error, 0);
    wave_loops = 20'h0_0000;
    @(negedge clk);
    check("config_error", config_error, 1);
    wave_loops = LOOP_MAX + 20'h0_0001;
    seq_enable = 1'b1;
    @(negedge clk);
    check("config_error", config_error, 1);
    wave_loops = LOOP_MAX;
    seq_loops = 20'h0_0000;
    @(negedge clk);
    check("config_error", config_error, 1);
    seq_loops = LOOP_MIN;
    seq_enable = 1'b0;
    // each trigger slope on both directions of the pin
    for (int sl = 0; sl < 3; sl++)
    begin
      trig_slope = tsg_slope_t'(sl);
      pin_starts(0, 1'b1, sl != 1);
      pin_starts(0, 1'b0, sl != 0);
    end
    // external source: bus refused, button accepted
    bus_pulse(1'b0);
    count_starts(n);
    check("starts", n, 0);
    pin_starts(2, 1'b1, 1);
    src_u.drive(2, 1'b0);
    cfg(RUN_TRIG, SRC_EVENT, 1'b0);
    pin_starts(2, 1'b1, 0);
    src_u.drive(2, 1'b0);
    // event input has rising or falling only
    for (int f = 0; f < 2; f++)
    begin
      event_slope_fall = f[0];
      pin_starts(1, 1'b1, f == 0);
      pin_starts(1, 1'b0, f == 1);
    end
    // bus source ignores pins and button, then counts a burst
    cfg(RUN_TRIG, SRC_BUS, 1'b0);
    for (int w = 0; w < 3; w++)
    begin
      pin_starts(w, 1'b1, 0);
      src_u.drive(w, 1'b0);
    end
    wave_loops = LOOP_W'(1 + $urandom % 4);
    bus_pulse(1'b0);
    count_starts(n);
    check("starts", n, 1);
    for (int k = 1; k <= int'(wave_loops); k++)
    begin
      done_pulse();
      check("active", output_active, k < int'(wave_loops));
    end
    // sequence: an auto step wraps once, then a jump step waits for the event
    seq_enable = 1'b1;
    event_slope_fall = 1'b0;
    seq_loops = 20'h0_0002;
    wave_loops = LOOP_MIN;
    bus_pulse(1'b0);
    for (int k = 2; k > 0; k--)
    begin
      done_pulse();
      check("step_advance", step_advance, 1);
      check("seq_wrap", seq_wrap, k == 2);
      check("active", output_active, k == 2);
    end
    jump_bit = 1'b1;
    bus_pulse(1'b0);
    done_pulse();
    check("step_advance", step_advance, 0);
    check("active", output_active, 1);
    src_u.drive(1, 1'b1);
    repeat (4) @(negedge clk);
    check("step_advance", step_advance, 1);
    bus_pulse(1'b1);
    {seq_enable, jump_bit} = '0;
    // gated: idle level, open on rise, close on fall
    gate_level_high = 1'b1;
    cfg(RUN_GATE, SRC_EXT, 1'b1);
    repeat (4) @(negedge clk);
    check("idle_dc", idle_dc, 1);
    check("gate_open", gate_open, 0);
    src_u.drive(0, 1'b1);
    repeat (8) @(negedge clk);
    check("gate_open", gate_open, 1);
    check("active", output_active, 1);
    src_u.drive(0, 1'b0);
    repeat (8) @(negedge clk);
    check("gate_open", gate_open, 0);
    check("active", output_active, 0);
    give_verdict();
  end
endmodule : test_tsg_ctrl
